// ==== rtl/psr_latch_cell.sv ====
// Purpose: One latching status flag, latch-high or latch-low
// Assumes: cond_i is an event pulse (high mode) or a live level (low mode)
// Notes: Setting condition wins over a clear in the same cycle
`timescale 1ns/1ns
module psr_latch_cell #(
    parameter bit LATCH_LOW = 1'b0
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic cond_i,
    input wire logic clr_i,
    output logic flag_o
);

    psr_pkg::psr_cell_s st_q;
    psr_pkg::psr_cell_s st_d;

    always_comb begin
        st_d = st_q;
        if (LATCH_LOW) begin
            // Drop holds until a read reloads the live level
            st_d.flag = clr_i ? cond_i : (st_q.flag & cond_i);
        end else begin
            st_d.flag = cond_i | (st_q.flag & ~clr_i);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign flag_o = st_q.flag;

endmodule

// ==== rtl/psr_pkg.sv ====
// Purpose: Shared constants and carrier types for the PHY status summary register
// Assumes: 5-bit management register addresses, 16-bit register data
// Notes: Flag index k of the latch bank maps to register bit FLAG_LSB + k
package psr_pkg;

    localparam logic [4:0] ADDR_BASIC_STATUS = 5'h01;
    localparam logic [4:0] ADDR_AN_EXPANSION = 5'h06;
    localparam logic [4:0] ADDR_SUMMARY = 5'h10;
    localparam logic [4:0] ADDR_INT_STATUS = 5'h12;
    localparam logic [4:0] ADDR_FALSE_CARRIER = 5'h14;
    localparam logic [4:0] ADDR_RX_ERROR = 5'h15;

    localparam int REG_W = 16;
    localparam int BIT_RESERVED = 15;
    localparam int BIT_XOVER = 14;
    localparam int BIT_AN_DONE = 4;
    localparam int BIT_LINK = 0;

    localparam int FLAG_N = 8;
    localparam int FLAG_LSB = 6;
    localparam int IDX_REMOTE_FAULT = 0;
    localparam int IDX_INT_PENDING = 1;
    localparam int IDX_PAGE_RX = 2;
    localparam int IDX_DESCR_LOCK = 3;
    localparam int IDX_SIGNAL_DET = 4;
    localparam int IDX_FALSE_CARRIER = 5;
    localparam int IDX_POLARITY = 6;
    localparam int IDX_RX_ERROR = 7;
    // Flags that latch low instead of high
    localparam logic [FLAG_N-1:0] LATCH_LOW_MASK = 8'h18;

    localparam logic [REG_W-1:0] REG_RESET = 16'h0000;

    typedef struct packed {
        logic stb;
        logic [4:0] addr;
    } psr_rd_s;

    typedef struct packed {
        logic rx_error;
        logic false_carrier;
        logic polarity_inverted;
        logic page_received;
        logic int_event;
        logic remote_fault;
    } psr_evt_s;

    typedef struct packed {
        logic signal_detect;
        logic descr_lock;
        logic link_up;
        logic an_done;
        logic xover_swapped;
        logic xover_auto_enable;
        logic xover_force;
    } psr_live_s;

    typedef struct packed {
        logic flag;
    } psr_cell_s;

endpackage

// ==== rtl/psr_status_summary.sv ====
// Purpose: Consolidated read-only PHY status summary register
// Assumes: Management reads arrive as one-cycle strobes with an address
// Notes: Read data returns one cycle after the strobe
// Behaviour
// - A read-only summary register answers management reads at address 0x10 in one access.
// - Bit 15 is reserved, ignores writes and always reads zero.
// - Bit 14 reads 1 when the pairs are swapped and 0 for normal pair use.
// - Bit 14 follows the crossover force and auto enable settings and tracks the algorithm live when only enabled.
// - Bit 13 latches high on a receive error and clears on a read of the receive error counter at 0x15.
// - Bit 12 mirrors the 10BASE-T polarity flag, 1 meaning inverted polarity.
// - The polarity bit clears on a 10BASE-T status register read and not on a summary read.
// - Bit 11 latches high on a false carrier and clears on a read of the false carrier counter at 0x14.
// - Bit 10 shows the 100BASE-TX signal detect and latches low when it is lost.
// - Bit 9 shows the descrambler lock and latches low when it is lost.
// - Bit 8 copies the page received flag, cleared by an expansion register read at 0x06 only.
// - Bit 7 is 1 while an interrupt is pending and a read of 0x12 clears it.
// - Bit 6 sets on a partner remote fault and clears on a basic status read at 0x01 or reset.
// - Bit 0 copies the link flag and a summary read does not clear it.
// - Bit 4 reads 1 once auto-negotiation has completed.
`timescale 1ns/1ns
module psr_status_summary #(
    parameter logic [4:0] ADDR_TENBASE = 5'h18
) (
    input wire logic SYS_CLK_I,
    input wire logic RST_B_I,
    input wire psr_pkg::psr_rd_s RD_REQ_I,
    input wire psr_pkg::psr_evt_s EVT_I,
    input wire psr_pkg::psr_live_s LIVE_I,
    output logic RD_VALID_O,
    output logic [15:0] RD_DATA_O
);

    typedef struct packed {
        logic xover;
        logic link;
        logic an_done;
        logic rd_valid;
        logic [psr_pkg::REG_W-1:0] rd_data;
    } psr_top_s;

    psr_top_s st_q;
    psr_top_s st_d;
    logic [psr_pkg::FLAG_N-1:0] cond;
    logic [psr_pkg::FLAG_N-1:0] clr;
    logic [psr_pkg::FLAG_N-1:0] flags;
    logic [psr_pkg::REG_W-1:0] view;

    function automatic logic rd_hit(input psr_pkg::psr_rd_s r, input logic [4:0] a);
        rd_hit = r.stb && (r.addr == a);
    endfunction

    function automatic logic xover_sel(input psr_pkg::psr_live_s l);
        if (l.xover_force) begin
            xover_sel = 1'b1;
        end else if (l.xover_auto_enable) begin
            xover_sel = l.xover_swapped;
        end else begin
            xover_sel = 1'b0;
        end
    endfunction

    always_comb begin
        cond = '0;
        clr = '0;
        cond[psr_pkg::IDX_RX_ERROR] = EVT_I.rx_error;
        clr[psr_pkg::IDX_RX_ERROR] = rd_hit(RD_REQ_I, psr_pkg::ADDR_RX_ERROR);
        cond[psr_pkg::IDX_POLARITY] = EVT_I.polarity_inverted;
        clr[psr_pkg::IDX_POLARITY] = rd_hit(RD_REQ_I, ADDR_TENBASE);
        cond[psr_pkg::IDX_FALSE_CARRIER] = EVT_I.false_carrier;
        clr[psr_pkg::IDX_FALSE_CARRIER] = rd_hit(RD_REQ_I, psr_pkg::ADDR_FALSE_CARRIER);
        cond[psr_pkg::IDX_SIGNAL_DET] = LIVE_I.signal_detect;
        clr[psr_pkg::IDX_SIGNAL_DET] = rd_hit(RD_REQ_I, psr_pkg::ADDR_SUMMARY);
        cond[psr_pkg::IDX_DESCR_LOCK] = LIVE_I.descr_lock;
        clr[psr_pkg::IDX_DESCR_LOCK] = rd_hit(RD_REQ_I, psr_pkg::ADDR_SUMMARY);
        cond[psr_pkg::IDX_PAGE_RX] = EVT_I.page_received;
        clr[psr_pkg::IDX_PAGE_RX] = rd_hit(RD_REQ_I, psr_pkg::ADDR_AN_EXPANSION);
        cond[psr_pkg::IDX_INT_PENDING] = EVT_I.int_event;
        clr[psr_pkg::IDX_INT_PENDING] = rd_hit(RD_REQ_I, psr_pkg::ADDR_INT_STATUS);
        cond[psr_pkg::IDX_REMOTE_FAULT] = EVT_I.remote_fault;
        clr[psr_pkg::IDX_REMOTE_FAULT] = rd_hit(RD_REQ_I, psr_pkg::ADDR_BASIC_STATUS);
    end

    for (genvar k = 0; k < psr_pkg::FLAG_N; k++) begin : g_flag
        psr_latch_cell #(
            .LATCH_LOW(psr_pkg::LATCH_LOW_MASK[k])
        ) u_cell (
            .clk_i(SYS_CLK_I),
            .rst_b_i(RST_B_I),
            .cond_i(cond[k]),
            .clr_i(clr[k]),
            .flag_o(flags[k])
        );
    end

    always_comb begin
        view = psr_pkg::REG_RESET;
        view[psr_pkg::BIT_RESERVED] = 1'b0;
        view[psr_pkg::BIT_XOVER] = st_q.xover;
        view[psr_pkg::FLAG_LSB +: psr_pkg::FLAG_N] = flags;
        view[psr_pkg::BIT_AN_DONE] = st_q.an_done;
        view[psr_pkg::BIT_LINK] = st_q.link;
    end

    always_comb begin
        st_d = st_q;
        st_d.xover = xover_sel(LIVE_I);
        st_d.link = LIVE_I.link_up;
        st_d.an_done = LIVE_I.an_done;
        st_d.rd_valid = rd_hit(RD_REQ_I, psr_pkg::ADDR_SUMMARY);
        if (rd_hit(RD_REQ_I, psr_pkg::ADDR_SUMMARY)) begin
            st_d.rd_data = view;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_B_I) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign RD_VALID_O = st_q.rd_valid;
    assign RD_DATA_O = st_q.rd_data;

    default clocking cb @(posedge SYS_CLK_I);
    endclocking
    default disable iff (!RST_B_I);

    sequence s_rd_sum;
        rd_hit(RD_REQ_I, psr_pkg::ADDR_SUMMARY);
    endsequence

    sequence s_rd_other;
        RD_REQ_I.stb && (RD_REQ_I.addr != psr_pkg::ADDR_SUMMARY);
    endsequence

    chk_read_answer_once: assert property (s_rd_sum |=> RD_VALID_O)
        else $error("Summary read not answered in one cycle");
    chk_other_addr_quiet: assert property (s_rd_other and !$past(RD_REQ_I.stb) |=> !RD_VALID_O)
        else $error("Answer given for a foreign address");
    chk_reserved_zero: assert property (RD_VALID_O |-> !RD_DATA_O[psr_pkg::BIT_RESERVED])
        else $error("Reserved bit read nonzero");
    chk_xover_force_one: assert property (LIVE_I.xover_force ##1 s_rd_sum |=> RD_DATA_O[psr_pkg::BIT_XOVER])
        else $error("Forced crossover not reported");
    chk_xover_off_zero: assert property (
        !LIVE_I.xover_force && !LIVE_I.xover_auto_enable ##1 s_rd_sum |=> !RD_DATA_O[psr_pkg::BIT_XOVER])
        else $error("Crossover reported while disabled");
    chk_rxerr_set_hold: assert property (
        EVT_I.rx_error ##1 !rd_hit(RD_REQ_I, psr_pkg::ADDR_RX_ERROR) ##1 s_rd_sum
        |=> RD_DATA_O[psr_pkg::FLAG_LSB + psr_pkg::IDX_RX_ERROR])
        else $error("Receive error latch not set");
    chk_rxerr_clear: assert property (
        rd_hit(RD_REQ_I, psr_pkg::ADDR_RX_ERROR) && !EVT_I.rx_error |=> !flags[psr_pkg::IDX_RX_ERROR])
        else $error("Receive error latch not cleared");
    chk_pol_keep_sum: assert property (
        flags[psr_pkg::IDX_POLARITY] and s_rd_sum |=> flags[psr_pkg::IDX_POLARITY])
        else $error("Polarity cleared by summary read");
    chk_pol_clear: assert property (
        rd_hit(RD_REQ_I, ADDR_TENBASE) && !EVT_I.polarity_inverted |=> !flags[psr_pkg::IDX_POLARITY])
        else $error("Polarity not cleared by its register read");
    chk_fcar_set: assert property (EVT_I.false_carrier |=> flags[psr_pkg::IDX_FALSE_CARRIER])
        else $error("False carrier latch not set");
    chk_sd_drop_hold: assert property (
        !LIVE_I.signal_detect ##1 (!rd_hit(RD_REQ_I, psr_pkg::ADDR_SUMMARY)) [*2]
        |=> !flags[psr_pkg::IDX_SIGNAL_DET])
        else $error("Signal detect drop not held");
    chk_lock_reload: assert property (s_rd_sum and LIVE_I.descr_lock |=> flags[psr_pkg::IDX_DESCR_LOCK])
        else $error("Descrambler lock not reloaded on read");
    chk_page_keep: assert property (
        flags[psr_pkg::IDX_PAGE_RX] && !rd_hit(RD_REQ_I, psr_pkg::ADDR_AN_EXPANSION)
        |=> flags[psr_pkg::IDX_PAGE_RX])
        else $error("Page received lost without expansion read");
    chk_int_clear: assert property (
        rd_hit(RD_REQ_I, psr_pkg::ADDR_INT_STATUS) && !EVT_I.int_event |=> !flags[psr_pkg::IDX_INT_PENDING])
        else $error("Interrupt pending not cleared");
    chk_fault_clear: assert property (
        rd_hit(RD_REQ_I, psr_pkg::ADDR_BASIC_STATUS) && !EVT_I.remote_fault
        |=> !flags[psr_pkg::IDX_REMOTE_FAULT])
        else $error("Remote fault not cleared");
    chk_link_follow: assert property (LIVE_I.link_up ##1 s_rd_sum |=> RD_DATA_O[psr_pkg::BIT_LINK])
        else $error("Link bit does not follow link");
    chk_an_follow: assert property (!LIVE_I.an_done ##1 s_rd_sum |=> !RD_DATA_O[psr_pkg::BIT_AN_DONE])
        else $error("Autoneg bit set while incomplete");
    chk_reset_clear: assert property (
        disable iff (1'b0) !RST_B_I |=> !RD_VALID_O && RD_DATA_O == '0 && flags == '0)
        else $error("State not zero after reset");

endmodule

// ==== testbench/psr_mgmt_model.sv ====
// Purpose: Management controller model issuing register reads
// Assumes: One read in flight, answer one cycle after the strobe
// Notes: Address idles to the inverse of the last one between reads
`timescale 1ns/1ns
module psr_mgmt_model (
    input wire logic clk_i,
    input wire logic valid_i,
    input wire logic [15:0] data_i,
    output psr_pkg::psr_rd_s rd_o
);
    initial rd_o = '{stb: 1'b0, addr: 5'h1f};
    // Strobe for one edge, then collect the answer
    task automatic rd(input logic [4:0] a, output logic v, output logic [15:0] d);
        @(posedge clk_i);
        #1 rd_o = '{stb: 1'b1, addr: a};
        @(posedge clk_i);
        #1 rd_o = '{stb: 1'b0, addr: ~a};
        v = valid_i;
        d = data_i;
    endtask
endmodule

// ==== testbench/psr_status_summary_tb_top.sv ====
// Purpose: Self-checking bench for the status summary register
// Assumes: Read answer one cycle after the strobe
// Notes: Base word 0x0611 has link, autoneg done and both latch-low bits up
`timescale 1ns/1ns
module psr_status_summary_tb_top;
    logic sys_clk, rst_b, rd_valid;
    logic [15:0] rd_data;
    psr_pkg::psr_rd_s rd_req;
    psr_pkg::psr_evt_s evt;
    psr_pkg::psr_live_s live;
    int n_mismatch = 0;
    int checks = 0;
    int cyc = 0;
    int ebit [6] = '{5, 4, 3, 2, 1, 0};
    int rbit [6] = '{13, 11, 12, 8, 7, 6};
    logic [4:0] cadr [6] = '{5'h15, 5'h14, 5'h18, 5'h06, 5'h12, 5'h01};
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    psr_status_summary u_psr_status_summary (.SYS_CLK_I(sys_clk), .RST_B_I(rst_b), .RD_REQ_I(rd_req),
        .EVT_I(evt), .LIVE_I(live), .RD_VALID_O(rd_valid), .RD_DATA_O(rd_data));
    psr_mgmt_model u_psr_mgmt_model (.clk_i(sys_clk), .valid_i(rd_valid), .data_i(rd_data), .rd_o(rd_req));
    task automatic results;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    // Read one address, compare answer presence and data
    task automatic rq(input logic [4:0] a, input logic ev, input logic [15:0] ed);
        logic v;
        logic [15:0] d;
        u_psr_mgmt_model.rd(a, v, d);
        chk({15'h0, v}, {15'h0, ev}, "answer presence");
        if (ev) chk(d, ed, "read data");
    endtask
    task automatic pulse(input logic [5:0] e);
        @(posedge sys_clk);
        #1 evt = psr_pkg::psr_evt_s'(e);
        @(posedge sys_clk);
        #1 evt = '0;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            results();
        end
    end
    initial begin
        rst_b = 1'b0;
        evt = '0;
        live = '0;
        repeat (8) @(posedge sys_clk);
        #1 rst_b = 1'b1;
        live = 7'h78;
        rq(psr_pkg::ADDR_SUMMARY, 1'b1, 16'h0011);
        rq(psr_pkg::ADDR_SUMMARY, 1'b1, 16'h0611);
        rq(5'h02, 1'b0, 16'h0000);
        $display("test reset and access done");
        for (int i = 0; i < 8; i++) begin
            live = {4'hf, i[2:0]};
            rq(psr_pkg::ADDR_SUMMARY, 1'b1, 16'h0611 | {1'b0, i[0] | (i[1] & i[2]), 14'h0});
        end
        live = 7'h78;
        $display("test crossover done");
        for (int k = 0; k < 6; k++) begin
            pulse(6'h01 << ebit[k]);
            rq(psr_pkg::ADDR_SUMMARY, 1'b1, 16'h0611 | (16'h0001 << rbit[k]));
            rq(psr_pkg::ADDR_SUMMARY, 1'b1, 16'h0611 | (16'h0001 << rbit[k]));
            rq(cadr[(k + 1) % 6], 1'b0, 16'h0000);
            rq(psr_pkg::ADDR_SUMMARY, 1'b1, 16'h0611 | (16'h0001 << rbit[k]));
            rq(cadr[k], 1'b0, 16'h0000);
            rq(psr_pkg::ADDR_SUMMARY, 1'b1, 16'h0611);
        end
        $display("test latched events done");
        for (int k = 0; k < 2; k++) begin
            live = 7'h78 & ~(7'h40 >> k);
            @(posedge sys_clk);
            #1 live = 7'h78;
            @(posedge sys_clk);
            rq(psr_pkg::ADDR_SUMMARY, 1'b1, 16'h0611 & ~(16'h0400 >> k));
            rq(psr_pkg::ADDR_SUMMARY, 1'b1, 16'h0611);
        end
        live = 7'h60;
        rq(psr_pkg::ADDR_SUMMARY, 1'b1, 16'h0600);
        live = 7'h78;
        rq(psr_pkg::ADDR_SUMMARY, 1'b1, 16'h0611);
        $display("test latch-low and link done");
        pulse(6'h3f);
        @(posedge sys_clk);
        #1 rst_b = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1 rst_b = 1'b1;
        rq(psr_pkg::ADDR_SUMMARY, 1'b1, 16'h0011);
        $display("test mid-run reset done");
        results();
    end
endmodule
